// ---- design/touch_pkg.sv ----
// Behaviour
// - transfers of eight clocks, conversion 24 clocks
// - host sends command in first eight clocks
// - acquire when channel known, hold three later
// - one busy clock then twelve result clocks
// - ratiometric keeps panel switches on converting
// - trailing three clocks output low, ignored
// - start bit one; ignore input before it
// - command MSB first, fixed field layout
// - mode bit low twelve, high eight bits
// - reference bit high single-ended, low differential
// - next command every 16th or 12th clock; the host starts one only after a full 24-clock frame
// - overlapped commands give sixteen-clock conversions; the host never overlaps frames
// - code 00 powers down, pen on, Y-minus on
// - code 01 powers down, pen off, Y-minus off
// - code 11 full power; 10 reserved
// - host finishes conversion within 1.6 ms
// - stay powered while host talks elsewhere
// - eight-bit conversion four clocks shorter
// - result is unsigned straight binary
// - single-ended: switches on only while acquiring
package touch_pkg;
   // command byte layout
   localparam int CMD_W        = 8;
   localparam int CMD_START    = 7;
   localparam int CMD_CHAN_HI  = 6;
   localparam int CMD_CHAN_LO  = 4;
   localparam int CMD_MODE     = 3;
   localparam int CMD_REF      = 2;
   localparam int CMD_PD_HI    = 1;
   localparam int CMD_PD_LO    = 0;
   // channel codes that drive panel switches
   localparam logic [2:0] CHAN_X_POS = 3'h1;
   localparam logic [2:0] CHAN_Y_POS = 3'h5;
   // power-down codes
   localparam logic [1:0] PD_AUTO_PEN = 2'h0;
   localparam logic [1:0] PD_AUTO     = 2'h1;
   localparam logic [1:0] PD_RESERVED = 2'h2;
   localparam logic [1:0] PD_FULL     = 2'h3;
   // sequencing counts in serial clocks
   localparam int SAMPLE_W     = 12;
   localparam int BITS_HI      = 12;
   localparam int BITS_LO      = 8;
   localparam int RX_ACQ_CNT   = 5;
   localparam int RX_FULL_CNT  = 8;
   localparam int FRAME_CLKS   = 24;
   // host serial clock timing
   localparam int CLK_SYS_NS   = 50;
   localparam int SCLK_HALF_NS = 500;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
   // host register map
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RESULT = 4'h8;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int RX_RES_HI = 14;
   localparam int RX_RES_LO = 3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : touch_pkg

// ---- design/touch_link_if.sv ----
`timescale 1ns/1ps
interface touch_link_if;
   logic csN;
   logic sclk;
   logic sdi;
   logic sdoOut;
   logic sdoOe;
   logic busyOut;
   logic busyOe;
   wire  sdo;
   wire  busy;
   // released pins read as their pull-down level
   assign sdo  = sdoOe & sdoOut;
   assign busy = busyOe & busyOut;
   modport device (input csN, input sclk, input sdi,
                   output sdoOut, output sdoOe, output busyOut, output busyOe);
   modport host (output csN, output sclk, output sdi, input sdo);
endinterface : touch_link_if

// ---- design/pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
   parameter int         W        = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         reset,
   // raw and filtered levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
   logic [W-1:0] q_next;
   // accept a bit once stages two and three agree
   always_comb begin
      q_next = q_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) q_next[i] = s2_reg[i];
      end
   end
   // three-stage capture
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
         q_reg  <= RESET_VAL;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= q_next;
      end
   end
   assign q = q_reg;
endmodule : pin_sync

// ---- design/touch_adc_device.sv ----
`timescale 1ns/1ps
module touch_adc_device (
   // clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           reset,
   // serial link
   touch_link_if.device                        link,
   // value presented by the analog front end
   input  wire logic [touch_pkg::SAMPLE_W-1:0] sampleValue,
   // converter configuration and state
   output logic      [2:0]                     channel_select,
   output logic                                reference_mode_select,
   output logic                                eightBit,
   output logic                                sampling,
   output logic                                converting,
   output logic                                fullPower,
   // panel drive
   output logic                                xSwitchOn,
   output logic                                ySwitchOn,
   output logic                                yMinusOn,
   output logic                                pen_touch_interrupt_en
);
   import touch_pkg::*;

   logic [2:0] pinRaw, pinSync;
   logic       selected, sclkLvl, sdiLvl;
   logic       sclkPrev_reg, sclkPrev_next;
   logic       sclkRise, sclkFall;

   // command receiver state
   logic [3:0]          rxCnt_reg, rxCnt_next;
   logic [6:0]          rxShift_reg, rxShift_next;
   logic [6:0]          rxNew;
   logic [CMD_W-1:0]    cmdByte;
   logic [2:0]          chan_reg, chan_next;
   logic                mode8_reg, mode8_next;
   logic                refSe_reg, refSe_next;
   logic [1:0]          pd_reg, pd_next;
   logic                samp_reg, samp_next;

   // conversion and output state
   typedef enum logic {CONV_IDLE, CONV_RUN} conv_t;
   conv_t               conv_reg, conv_next;
   logic [3:0]          convCnt_reg, convCnt_next;
   logic [3:0]          convBits;
   logic [SAMPLE_W-1:0] data_reg, data_next;
   logic                sdo_reg, sdo_next;
   logic                busy_reg, busy_next;
   logic                oe_reg, oe_next;

   // registered user outputs
   logic xSw_reg, xSw_next, ySw_reg, ySw_next;
   logic yMin_reg, yMin_next, pen_reg, pen_next, pwr_reg, pwr_next;
   logic swOn, asleep;

   // pins from the far side enter through the filter
   assign pinRaw = {link.csN, link.sclk, link.sdi};
   pin_sync #(.W(3), .RESET_VAL(3'h4)) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .d       (pinRaw),
      .q       (pinSync)
   );
   assign selected = ~pinSync[2];
   assign sclkLvl  = pinSync[1];
   assign sdiLvl   = pinSync[0];

   // serial clock edges, counted only while selected
   assign sclkRise = selected & sclkLvl & ~sclkPrev_reg;
   assign sclkFall = selected & ~sclkLvl & sclkPrev_reg;
   assign rxNew    = {rxShift_reg[5:0], sdiLvl};
   assign cmdByte  = {1'b1, rxNew};
   assign convBits = mode8_reg ? 4'(BITS_LO) : 4'(BITS_HI);

   // next state of receiver, converter and shifter
   always_comb begin
      sclkPrev_next = sclkLvl;
      rxCnt_next    = rxCnt_reg;
      rxShift_next  = rxShift_reg;
      chan_next     = chan_reg;
      mode8_next    = mode8_reg;
      refSe_next    = refSe_reg;
      pd_next       = pd_reg;
      samp_next     = samp_reg;
      conv_next     = conv_reg;
      convCnt_next  = convCnt_reg;
      data_next     = data_reg;
      sdo_next      = sdo_reg;
      busy_next     = busy_reg;
      oe_next       = selected;
      if (sclkRise) begin
         if (rxCnt_reg == 4'h0) begin
            // hunt for the start bit
            if (sdiLvl) rxCnt_next = 4'h1;
         end else begin
            rxShift_next = rxNew;
            rxCnt_next   = rxCnt_reg + 4'h1;
            if (rxCnt_reg + 4'h1 == 4'(RX_ACQ_CNT)) begin
               // channel known: start sampling
               chan_next = rxNew[3:1];
               samp_next = 1'b1;
            end
            if (rxCnt_reg + 4'h1 == 4'(RX_FULL_CNT)) begin
               // command complete: hold and convert
               chan_next    = cmdByte[CMD_CHAN_HI:CMD_CHAN_LO];
               mode8_next   = cmdByte[CMD_MODE];
               refSe_next   = cmdByte[CMD_REF];
               pd_next      = cmdByte[CMD_PD_HI:CMD_PD_LO];
               samp_next    = 1'b0;
               conv_next    = CONV_RUN;
               convCnt_next = 4'h0;
               data_next    = sampleValue;
               rxCnt_next   = 4'h0;
            end
         end
      end
      if (sclkFall) begin
         case (conv_reg)
            CONV_RUN: begin
               convCnt_next = convCnt_reg + 4'h1;
               if (convCnt_reg == 4'h0) begin
                  busy_next = 1'b1;
                  sdo_next  = 1'b0;
               end else if (convCnt_reg <= convBits) begin
                  // result bits MSB first
                  busy_next = 1'b0;
                  sdo_next  = data_reg[SAMPLE_W-1];
                  data_next = {data_reg[SAMPLE_W-2:0], 1'b0};
               end else begin
                  // trailing clocks read low
                  busy_next = 1'b0;
                  sdo_next  = 1'b0;
                  conv_next = CONV_IDLE;
               end
            end
            default: begin
               // idle clocks are ignored, output stays low
               busy_next = 1'b0;
               sdo_next  = 1'b0;
            end
         endcase
      end
   end

   // panel switches and power state
   always_comb begin
      swOn      = samp_reg | ((conv_reg == CONV_RUN) & ~refSe_reg);
      asleep    = ~samp_reg & (conv_reg == CONV_IDLE) & ~pd_reg[1];
      xSw_next  = swOn & (chan_reg == CHAN_Y_POS);
      ySw_next  = swOn & (chan_reg == CHAN_X_POS);
      yMin_next = ySw_next | (asleep & (pd_reg == PD_AUTO_PEN));
      pen_next  = asleep & (pd_reg == PD_AUTO_PEN);
      pwr_next  = ~asleep;
   end

   // state registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclkPrev_reg <= 1'b0;
         rxCnt_reg    <= 4'h0;
         rxShift_reg  <= 7'h00;
         chan_reg     <= 3'h0;
         mode8_reg    <= 1'b0;
         refSe_reg    <= 1'b1;
         pd_reg       <= PD_AUTO_PEN;
         samp_reg     <= 1'b0;
         conv_reg     <= CONV_IDLE;
         convCnt_reg  <= 4'h0;
         data_reg     <= '0;
         sdo_reg      <= 1'b0;
         busy_reg     <= 1'b0;
         oe_reg       <= 1'b0;
         xSw_reg      <= 1'b0;
         ySw_reg      <= 1'b0;
         yMin_reg     <= 1'b0;
         pen_reg      <= 1'b0;
         pwr_reg      <= 1'b0;
      end else begin
         sclkPrev_reg <= sclkPrev_next;
         rxCnt_reg    <= rxCnt_next;
         rxShift_reg  <= rxShift_next;
         chan_reg     <= chan_next;
         mode8_reg    <= mode8_next;
         refSe_reg    <= refSe_next;
         pd_reg       <= pd_next;
         samp_reg     <= samp_next;
         conv_reg     <= conv_next;
         convCnt_reg  <= convCnt_next;
         data_reg     <= data_next;
         sdo_reg      <= sdo_next;
         busy_reg     <= busy_next;
         oe_reg       <= oe_next;
         xSw_reg      <= xSw_next;
         ySw_reg      <= ySw_next;
         yMin_reg     <= yMin_next;
         pen_reg      <= pen_next;
         pwr_reg      <= pwr_next;
      end
   end

   // pin and user outputs
   assign link.sdoOut            = sdo_reg;
   assign link.sdoOe             = oe_reg;
   assign link.busyOut           = busy_reg;
   assign link.busyOe            = oe_reg;
   assign channel_select         = chan_reg;
   assign reference_mode_select  = refSe_reg;
   assign eightBit               = mode8_reg;
   assign sampling               = samp_reg;
   assign converting             = (conv_reg == CONV_RUN);
   assign fullPower              = pwr_reg;
   assign xSwitchOn              = xSw_reg;
   assign ySwitchOn              = ySw_reg;
   assign yMinusOn               = yMin_reg;
   assign pen_touch_interrupt_en = pen_reg;
endmodule : touch_adc_device

// ---- design/touch_adc_host.sv ----
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module touch_adc_host (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // serial link
   touch_link_if.host       link,
   // axi4-lite write channels
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read channels
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import touch_pkg::*;

   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_END} host_t;
   host_t            st_reg, st_next;
   logic [4:0]       div_reg, div_next, bit_reg, bit_next;
   logic [CMD_W-1:0] cmd_reg, cmd_next;
   logic [23:0]      rx_reg, rx_next;
   logic             cs_reg, cs_next, sclk_reg, sclk_next, sdi_reg, sdi_next;
   logic             done_reg, done_next;
   logic             sdoLvl;
   // bus state
   logic [3:0]       awa_reg, awa_next;
   logic             awH_reg, awH_next, wH_reg, wH_next;
   logic [31:0]      wd_reg, wd_next;
   logic             bv_reg, bv_next, rv_reg, rv_next;
   logic [1:0]       br_reg, br_next, rr_reg, rr_next;
   logic [31:0]      rd_reg, rd_next;
   logic             wrFire, go;

   // returned data enters through the filter
   pin_sync #(.W(1), .RESET_VAL(1'b0)) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .d       (link.sdo),
      .q       (sdoLvl)
   );

   assign wrFire = awH_reg & wH_reg & ~bv_reg;
   assign go     = wrFire & (awa_reg == REG_CTRL) & wd_reg[CMD_START] & (st_reg == H_IDLE);

   // register slave
   always_comb begin
      awa_next = awa_reg;
      awH_next = awH_reg;
      wH_next  = wH_reg;
      wd_next  = wd_reg;
      bv_next  = bv_reg;
      br_next  = br_reg;
      rv_next  = rv_reg;
      rr_next  = rr_reg;
      rd_next  = rd_reg;
      if (s_axi_awvalid & ~awH_reg) begin
         awa_next = s_axi_awaddr;
         awH_next = 1'b1;
      end
      if (s_axi_wvalid & ~wH_reg) begin
         wd_next = s_axi_wdata;
         wH_next = 1'b1;
      end
      if (wrFire) begin
         awH_next = 1'b0;
         wH_next  = 1'b0;
         bv_next  = 1'b1;
         br_next  = (awa_reg == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
      end else if (bv_reg & s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid & ~rv_reg) begin
         rv_next = 1'b1;
         rr_next = RESP_OKAY;
         case (s_axi_araddr)
            REG_STATUS: rd_next = {30'h0, done_reg, st_reg != H_IDLE};
            REG_RESULT: rd_next = {20'h0, rx_reg[RX_RES_HI:RX_RES_LO]};
            REG_CTRL:   rd_next = {24'h0, cmd_reg};
            default: begin
               rd_next = 32'h0;
               rr_next = RESP_SLVERR;
            end
         endcase
      end else if (rv_reg & s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   // serial sequencer: 24 clocks per conversion
   always_comb begin
      st_next   = st_reg;
      div_next  = div_reg;
      bit_next  = bit_reg;
      cmd_next  = cmd_reg;
      rx_next   = rx_reg;
      cs_next   = cs_reg;
      sclk_next = sclk_reg;
      sdi_next  = sdi_reg;
      done_next = done_reg;
      if (go) done_next = 1'b0;
      if (div_reg != 5'h0) div_next = div_reg - 5'h1;
      case (st_reg)
         H_IDLE: begin
            if (go) begin
               cmd_next = wd_reg[CMD_W-1:0];
               cs_next  = 1'b0;
               sdi_next = wd_reg[CMD_START];
               bit_next = 5'h0;
               div_next = 5'(SCLK_HALF_CYC - 1);
               st_next  = H_SETUP;
            end
         end
         H_SETUP, H_LOW: begin
            if (div_reg == 5'h0) begin
               sclk_next = 1'b1;
               div_next  = 5'(SCLK_HALF_CYC - 1);
               st_next   = H_HIGH;
            end
         end
         H_HIGH: begin
            if (div_reg == 5'h0) begin
               // falling edge: sample previous output bit
               sclk_next = 1'b0;
               rx_next   = {rx_reg[22:0], sdoLvl};
               div_next  = 5'(SCLK_HALF_CYC - 1);
               bit_next  = bit_reg + 5'h1;
               if (bit_reg == 5'(FRAME_CLKS - 1)) begin
                  st_next = H_END;
               end else begin
                  sdi_next = (bit_reg < 5'(CMD_W - 1)) ? cmd_reg[6 - bit_reg[2:0]] : 1'b0;
                  st_next  = H_LOW;
               end
            end
         end
         H_END: begin
            if (div_reg == 5'h0) begin
               cs_next   = 1'b1;
               sdi_next  = 1'b0;
               done_next = 1'b1;
               st_next   = H_IDLE;
            end
         end
         default: st_next = H_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg <= H_IDLE;
         div_reg <= 5'h0;
         bit_reg <= 5'h0;
         cmd_reg <= '0;
         rx_reg <= 24'h0;
         cs_reg <= 1'b1;
         sclk_reg <= 1'b0;
         sdi_reg <= 1'b0;
         done_reg <= 1'b0;
         awa_reg <= 4'h0;
         awH_reg <= 1'b0;
         wH_reg <= 1'b0;
         wd_reg <= 32'h0;
         bv_reg <= 1'b0;
         br_reg <= RESP_OKAY;
         rv_reg <= 1'b0;
         rr_reg <= RESP_OKAY;
         rd_reg <= 32'h0;
      end else begin
         st_reg <= st_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         cmd_reg <= cmd_next;
         rx_reg <= rx_next;
         cs_reg <= cs_next;
         sclk_reg <= sclk_next;
         sdi_reg <= sdi_next;
         done_reg <= done_next;
         awa_reg <= awa_next;
         awH_reg <= awH_next;
         wH_reg <= wH_next;
         wd_reg <= wd_next;
         bv_reg <= bv_next;
         br_reg <= br_next;
         rv_reg <= rv_next;
         rr_reg <= rr_next;
         rd_reg <= rd_next;
      end
   end

   // outputs
   assign link.csN      = cs_reg;
   assign link.sclk     = sclk_reg;
   assign link.sdi      = sdi_reg;
   assign s_axi_awready = ~awH_reg;
   assign s_axi_wready  = ~wH_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;
   assign s_axi_arready = ~rv_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rresp   = rr_reg;
   assign s_axi_rdata   = rd_reg;
endmodule : touch_adc_host

// ---- verif/touch_link_props.sv ----
`timescale 1ns/1ps
module touch_link_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // link signals
   input wire logic csN,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdoOut,
   input wire logic sdoOe,
   input wire logic busyOut,
   input wire logic busyOe
);
   logic       sclkQ_reg, sclkQ_next, sclkRise, sclkFall;
   logic [4:0] riseCnt_reg, riseCnt_next, fallCnt_reg, fallCnt_next, tailStart;
   logic [7:0] cmd_reg, cmd_next;
   logic [15:0] lowCnt_reg, lowCnt_next;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // edge counters of one frame, command byte seen on sdi
   always_comb begin
      sclkRise     = sclk & ~sclkQ_reg;
      sclkFall     = ~sclk & sclkQ_reg;
      sclkQ_next   = sclk;
      riseCnt_next = csN ? 5'h0 : riseCnt_reg + {4'h0, sclkRise};
      fallCnt_next = csN ? 5'h0 : fallCnt_reg + {4'h0, sclkFall};
      cmd_next     = (sclkRise && riseCnt_reg < 5'h8) ? {cmd_reg[6:0], sdi} : cmd_reg;
      tailStart    = cmd_reg[3] ? 5'h11 : 5'h15;
      lowCnt_next  = csN ? 16'h0 : lowCnt_reg + 16'h1;
   end
   // register the helpers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sclkQ_reg   <= 1'b0;
         riseCnt_reg <= 5'h0;
         fallCnt_reg <= 5'h0;
         cmd_reg     <= 8'h0;
         lowCnt_reg  <= 16'h0;
      end else begin
         sclkQ_reg   <= sclkQ_next;
         riseCnt_reg <= riseCnt_next;
         fallCnt_reg <= fallCnt_next;
         cmd_reg     <= cmd_next;
         lowCnt_reg  <= lowCnt_next;
      end
   end
   AST_FRAME_LEN: assert property ($rose(csN) |-> riseCnt_reg == 5'h18 && fallCnt_reg == 5'h18)
      else $error("frame is not 24 serial clocks");
   AST_START_BIT: assert property (sclkRise && riseCnt_reg == 5'h0 |-> sdi)
      else $error("command does not open with a one");
   AST_CMD_TAIL: assert property (sclkRise && riseCnt_reg >= 5'h8 |-> !sdi)
      else $error("sdi not low after the command byte");
   AST_BUSY_PULSE: assert property (sclkRise |-> busyOut == (fallCnt_reg == 5'h8))
      else $error("busy not exactly the clock after hold");
   AST_RESULT_TAIL: assert property (sclkRise && fallCnt_reg >= tailStart |-> !sdoOut)
      else $error("sdo not low after the result");
   AST_HOLD_SDO: assert property (sclkRise && fallCnt_reg == 5'h8 |-> !sdoOut)
      else $error("sdo not low in the busy clock");
   AST_DRIVE_SEL: assert property (sclkRise && !csN |-> sdoOe && busyOe)
      else $error("outputs not driven while selected");
   AST_RELEASE: assert property ($rose(csN) |-> ##[1:8] !sdoOe && !busyOe)
      else $error("outputs not released after deselect");
   AST_SCLK_IDLE: assert property (csN |-> !sclk)
      else $error("serial clock moves while deselected");
   AST_HOLD_TIME: assert property (lowCnt_reg < 16'h7d00)
      else $error("conversion frame outlasts the held sample");
endmodule : touch_link_props

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import touch_pkg::*;
   logic                clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                s_axi_rvalid, s_axi_rready, reference_mode_select, eightBit, sampling;
   logic                converting, fullPower, xSwitchOn, ySwitchOn, yMinusOn;
   logic                pen_touch_interrupt_en;
   logic [3:0]          s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata, d;
   logic [1:0]          s_axi_bresp, s_axi_rresp, r;
   logic [SAMPLE_W-1:0] sampleValue;
   logic [2:0]          channel_select;
   logic [7:0]          c;
   int                  n_fail = 0, checks = 0, cyc = 0, k;
   logic [7:0]          cmds [5] = '{8'h97, 8'hd0, 8'h99, 8'ha2, 8'hdb};
   logic [11:0]         samps [5] = '{12'ha5c, 12'h3f1, 12'hfff, 12'h000, 12'h801};
   touch_link_if link ();
   touch_adc_device i_touch_adc_device (.clk_sys, .reset, .link(link), .sampleValue,
      .channel_select, .reference_mode_select, .eightBit, .sampling, .converting, .fullPower,
      .xSwitchOn, .ySwitchOn, .yMinusOn, .pen_touch_interrupt_en);
   touch_adc_host i_touch_adc_host (.clk_sys, .reset, .link(link), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   touch_link_props i_touch_link_props (.clk_sys, .reset, .csN(link.csN), .sclk(link.sclk),
      .sdi(link.sdi), .sdoOut(link.sdoOut), .sdoOe(link.sdoOe), .busyOut(link.busyOut),
      .busyOe(link.busyOe));
   // clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic chk1(input string nm, input logic seen, input logic exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask : chk1
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   // axi4-lite write, both channels offered together
   task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rsp);
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   // axi4-lite read
   task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   // main sequence
   initial begin
      reset = 1'b1;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      sampleValue = '0;
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      axr(4'hc, d, r);
      chk1("reset pen", pen_touch_interrupt_en, 1'b1);
      chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      chk("unmapped data", d, 32'h0);
      axw(REG_STATUS, 32'h3, r);
      chk("status write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      axw(REG_CTRL, 32'h17, r);
      repeat (40) @(posedge clk_sys);
      chk1("no start bit", link.csN, 1'b1);
      $display("test refusals done");
      for (int i = 0; i < 5; i++) begin
         c = cmds[i];
         sampleValue <= samps[i];
         axw(REG_CTRL, {24'h0, c}, r);
         chk("ctrl resp", {30'h0, r}, {30'h0, RESP_OKAY});
         axw(REG_CTRL, {24'h0, c ^ 8'h01}, r);
         for (k = 0; k < 2000 && sampling !== 1'b1; k++) @(posedge clk_sys);
         @(posedge clk_sys);
         chk("chan", {29'h0, channel_select}, {29'h0, c[6:4]});
         chk1("acq power", fullPower, 1'b1);
         chk1("acq x", xSwitchOn, c[6:4] == CHAN_Y_POS);
         chk1("acq y", ySwitchOn, c[6:4] == CHAN_X_POS);
         for (k = 0; k < 2000 && converting !== 1'b1; k++) @(posedge clk_sys);
         @(posedge clk_sys);
         chk1("hold", sampling, 1'b0);
         chk1("conv power", fullPower, 1'b1);
         chk1("conv x", xSwitchOn, !c[2] && c[6:4] == CHAN_Y_POS);
         chk1("conv y", ySwitchOn, !c[2] && c[6:4] == CHAN_X_POS);
         chk1("mode", eightBit, c[3]);
         chk1("ref", reference_mode_select, c[2]);
         d = '0;
         for (k = 0; k < 400 && d[ST_DONE] !== 1'b1; k++) axr(REG_STATUS, d, r);
         chk("status", d, 32'h1 << ST_DONE);
         axr(REG_RESULT, d, r);
         chk("result", d, c[3] ? {20'h0, samps[i][11:4], 4'h0} : {20'h0, samps[i]});
         axr(REG_CTRL, d, r);
         chk("ctrl kept", d, {24'h0, c});
         chk1("conv end", converting, 1'b0);
         chk1("pd power", fullPower, c[1]);
         chk1("pd pen", pen_touch_interrupt_en, c[1:0] == PD_AUTO_PEN);
         chk1("pd yminus", yMinusOn, c[1:0] == PD_AUTO_PEN);
         $display("test conversion %0d done", i);
      end
      complete_run();
   end
endmodule : tb_top
